/* hw/fsb_pkg.sv */
// Purpose: Shared constants and types for the stream buffer controller
// Assumes: APB with 32-bit data, register index times four gives byte address
// Notes: Indices are word indices, not byte addresses

package fsb_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int ADDR_W = 18;
  localparam int IDX_W = 16;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [15:0] IDX_COMMAND = 16'h0000;
  localparam logic [15:0] IDX_TALLY = 16'hea74;
  localparam logic [15:0] IDX_LIMIT = 16'hea7e;
  localparam logic [15:0] IDX_RELEASE = 16'hea92;
  localparam logic [15:0] IDX_NUM_BUFS = 16'heb00;
  localparam logic [15:0] IDX_BUF_LEN = 16'heb01;
  localparam logic [15:0] IDX_CHAN_EN = 16'heb02;
  localparam logic [15:0] IDX_IRQ_STAT = 16'heb03;
  localparam logic [15:0] IDX_IRQ_MASK = 16'heb04;
  localparam logic [15:0] IDX_STATUS = 16'heb05;
  localparam logic [15:0] IDX_LEGACY_REL = 16'heb10;
  localparam logic [11:0] LEGACY_GROUP = 12'heb1;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [31:0] CMD_BEGIN_BLOCK = 32'h0000_000c;
  localparam logic [31:0] CMD_NEXT_WAIT = 32'h0000_000d;
  localparam logic [31:0] CMD_BEGIN_NOWAIT = 32'h0000_000e;
  localparam logic [31:0] CMD_HALT = 32'h0000_0014;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [8:0] RST_NUM_BUFS = 9'h002;
  localparam logic [31:0] RST_BUF_LEN = 32'h0000_0400;
  localparam logic [7:0] RST_CHAN_EN = 8'hff;
  localparam logic [31:0] RST_LIMIT = 32'h0000_0000;

  // ****************************************
  // Event bits (status and mask share layout)
  // ****************************************
  localparam int EV_W = 3;
  localparam int EV_BUF_DONE = 0;
  localparam int EV_AUTO_STOP = 1;
  localparam int EV_STALL = 2;

  // ****************************************
  // Status word fields
  // ****************************************
  localparam int STS_RUN = 0;
  localparam int STS_STALL = 1;
  localparam int STS_WAIT = 2;
  localparam int STS_STAGE = 3;
  localparam int STS_IDX_LSB = 8;

  // Channel position k is held in bits [3k+2:3k]: 0,4,1,5,2,6,3,7
  localparam logic [23:0] CH_ORDER = 24'hef_2a60;

  typedef enum logic [2:0] {
    FSB_IDLE = 3'b001,
    FSB_RUN = 3'b010,
    FSB_STALL = 3'b100
  } fsb_state_t;

endpackage

/* hw/fsb_stream_ctrl.sv */
// Purpose: Streaming control that fills a ring of host buffers from channel samples
// Assumes: One clock; samples arrive one set per handshake; host takes every word
// Notes: APB slave answers after one wait state

`timescale 1ns/1ns

module fsb_stream_ctrl #(
  parameter int SAMPLE_W = 16
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fsb_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Sample input, one word per channel
  input wire logic sample_valid,
  input wire logic [8*SAMPLE_W-1:0] sample_data,
  output logic sample_ready,
  // Buffer word output
  output logic out_valid,
  output logic [SAMPLE_W-1:0] out_data,
  output logic [7:0] out_buf,
  output logic [31:0] out_word,
  output logic out_stage,
  // Host notification
  output logic irq,
  output logic wait_pending
);

  // ****************************************
  // State
  // ****************************************
  fsb_pkg::fsb_state_t st_r, st_nxt;
  logic [31:0] tally_r, tally_nxt, limit_r, limit_nxt, buflen_r, buflen_nxt;
  logic [31:0] wcnt_r, wcnt_nxt;
  logic [8:0] nbufs_r, nbufs_nxt;
  logic [7:0] chen_r, chen_nxt, pend_r, pend_nxt, idx_r, idx_nxt;
  logic [fsb_pkg::EV_W-1:0] istat_r, istat_nxt, imask_r, imask_nxt, ev;
  logic wait_r, wait_nxt, stage_r, stage_nxt;
  logic [255:0] free_r, free_nxt;
  logic [8*SAMPLE_W-1:0] hold_r, hold_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic ovalid_r, ovalid_nxt, ostage_r, ostage_nxt, sready_r, sready_nxt, irq_r, irq_nxt;
  logic [SAMPLE_W-1:0] odata_r, odata_nxt;
  logic [7:0] obuf_r, obuf_nxt;
  logic [31:0] oword_r, oword_nxt;
  logic [15:0] ridx;
  logic wr, setup, mapped;
  logic [3:0] pk;
  logic [31:0] rdmux;

  // First enabled channel in the fixed interleave order
  function automatic logic [3:0] fsb_pick(input logic [7:0] m);
    logic [3:0] r;
    logic [2:0] c;
    r = 4'h0;
    for (int k = 7; k >= 0; k--) begin
      c = fsb_pkg::CH_ORDER[3*k +: 3];
      if (m[c]) begin
        r = {1'b1, c};
      end
    end
    return r;
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    tally_nxt = tally_r;
    limit_nxt = limit_r;
    buflen_nxt = buflen_r;
    wcnt_nxt = wcnt_r;
    nbufs_nxt = nbufs_r;
    chen_nxt = chen_r;
    pend_nxt = pend_r;
    idx_nxt = idx_r;
    imask_nxt = imask_r;
    wait_nxt = wait_r;
    stage_nxt = stage_r;
    free_nxt = free_r;
    hold_nxt = hold_r;
    ev = '0;
    ovalid_nxt = 1'b0;
    odata_nxt = odata_r;
    obuf_nxt = obuf_r;
    oword_nxt = oword_r;
    ostage_nxt = ostage_r;
    ridx = paddr[fsb_pkg::ADDR_W-1:2];
    setup = psel & penable & ~pready_r;
    wr = psel & penable & pready_r & pwrite;
    pk = fsb_pick(pend_r);

    // Datapath
    if (st_r == fsb_pkg::FSB_RUN) begin
      if (pend_r != 8'h00) begin
        if (wcnt_r == 32'h0000_0000 && !free_r[idx_r]) begin
          st_nxt = fsb_pkg::FSB_STALL;
          ev[fsb_pkg::EV_STALL] = 1'b1;
        end else begin
          ovalid_nxt = 1'b1;
          odata_nxt = hold_r[pk[2:0]*SAMPLE_W +: SAMPLE_W];
          obuf_nxt = idx_r;
          oword_nxt = wcnt_r;
          ostage_nxt = stage_r;
          pend_nxt[pk[2:0]] = 1'b0;
          if (wcnt_r == 32'h0000_0000) begin
            free_nxt[idx_r] = 1'b0;
          end
          if (wcnt_r == (buflen_r >> 1) - 32'h0000_0001) begin
            wcnt_nxt = 32'h0000_0000;
            idx_nxt = (9'(idx_r) == nbufs_r - 9'h001) ? 8'h00 : idx_r + 8'h01;
            stage_nxt = ~stage_r;
            tally_nxt = tally_r + 32'h0000_0001;
            ev[fsb_pkg::EV_BUF_DONE] = 1'b1;
            wait_nxt = 1'b0;
            if (limit_r != 32'h0000_0000 && tally_nxt == limit_r) begin
              st_nxt = fsb_pkg::FSB_IDLE;
              pend_nxt = 8'h00;
              ev[fsb_pkg::EV_AUTO_STOP] = 1'b1;
            end
          end else begin
            wcnt_nxt = wcnt_r + 32'h0000_0001;
          end
        end
      end else if (sample_valid && sready_r) begin
        hold_nxt = sample_data;
        pend_nxt = chen_r;
      end
    end else if (st_r == fsb_pkg::FSB_STALL && free_r[idx_r]) begin
      st_nxt = fsb_pkg::FSB_RUN;
    end

    // Register writes; release set wins over the fill clear
    if (wr) begin
      case (ridx)
        fsb_pkg::IDX_COMMAND: begin
          case (pwdata)
            fsb_pkg::CMD_BEGIN_BLOCK, fsb_pkg::CMD_BEGIN_NOWAIT: begin
              st_nxt = fsb_pkg::FSB_RUN;
              tally_nxt = 32'h0000_0000;
              idx_nxt = 8'h00;
              wcnt_nxt = 32'h0000_0000;
              stage_nxt = 1'b0;
              pend_nxt = 8'h00;
              free_nxt = '1;
              wait_nxt = (pwdata == fsb_pkg::CMD_BEGIN_BLOCK);
            end
            fsb_pkg::CMD_NEXT_WAIT: begin
              wait_nxt = (st_r != fsb_pkg::FSB_IDLE);
            end
            fsb_pkg::CMD_HALT: begin
              st_nxt = fsb_pkg::FSB_IDLE;
              pend_nxt = 8'h00;
              wait_nxt = 1'b0;
            end
            default: begin
            end
          endcase
        end
        fsb_pkg::IDX_LIMIT: limit_nxt = pwdata;
        fsb_pkg::IDX_RELEASE: free_nxt[pwdata[7:0]] = 1'b1;
        fsb_pkg::IDX_NUM_BUFS: nbufs_nxt = pwdata[8:0];
        fsb_pkg::IDX_BUF_LEN: buflen_nxt = pwdata;
        fsb_pkg::IDX_CHAN_EN: chen_nxt = pwdata[7:0];
        fsb_pkg::IDX_IRQ_MASK: imask_nxt = pwdata[fsb_pkg::EV_W-1:0];
        default: begin
          if (ridx[15:4] == fsb_pkg::LEGACY_GROUP) begin
            free_nxt[{4'h0, ridx[3:0]}] = 1'b1;
          end
        end
      endcase
    end

    // Sticky events, write one to clear, a new event wins
    istat_nxt = istat_r;
    if (wr && ridx == fsb_pkg::IDX_IRQ_STAT) begin
      istat_nxt = istat_r & ~pwdata[fsb_pkg::EV_W-1:0];
    end
    istat_nxt = istat_nxt | ev;
    irq_nxt = |(istat_nxt & imask_nxt);
    sready_nxt = (st_nxt == fsb_pkg::FSB_RUN) && (pend_nxt == 8'h00);

    // Read mux; write-only words read as zero
    mapped = 1'b1;
    case (ridx)
      fsb_pkg::IDX_TALLY: rdmux = tally_r;
      fsb_pkg::IDX_LIMIT: rdmux = limit_r;
      fsb_pkg::IDX_NUM_BUFS: rdmux = {23'h00_0000, nbufs_r};
      fsb_pkg::IDX_BUF_LEN: rdmux = buflen_r;
      fsb_pkg::IDX_CHAN_EN: rdmux = {24'h00_0000, chen_r};
      fsb_pkg::IDX_IRQ_STAT: rdmux = {29'h0000_0000, istat_r};
      fsb_pkg::IDX_IRQ_MASK: rdmux = {29'h0000_0000, imask_r};
      fsb_pkg::IDX_STATUS: begin
        rdmux = 32'h0000_0000;
        rdmux[fsb_pkg::STS_RUN] = (st_r == fsb_pkg::FSB_RUN);
        rdmux[fsb_pkg::STS_STALL] = (st_r == fsb_pkg::FSB_STALL);
        rdmux[fsb_pkg::STS_WAIT] = wait_r;
        rdmux[fsb_pkg::STS_STAGE] = stage_r;
        rdmux[fsb_pkg::STS_IDX_LSB +: 8] = idx_r;
      end
      fsb_pkg::IDX_COMMAND, fsb_pkg::IDX_RELEASE: rdmux = 32'h0000_0000;
      default: begin
        rdmux = 32'h0000_0000;
        mapped = (ridx[15:4] == fsb_pkg::LEGACY_GROUP);
      end
    endcase
    // One wait state gives every output a flop source
    pready_nxt = setup;
    prdata_nxt = setup ? (pwrite ? 32'h0000_0000 : rdmux) : prdata_r;
    pslverr_nxt = setup & ~mapped;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= fsb_pkg::FSB_IDLE;
      tally_r <= 32'h0000_0000;
      limit_r <= fsb_pkg::RST_LIMIT;
      buflen_r <= fsb_pkg::RST_BUF_LEN;
      wcnt_r <= 32'h0000_0000;
      nbufs_r <= fsb_pkg::RST_NUM_BUFS;
      chen_r <= fsb_pkg::RST_CHAN_EN;
      pend_r <= 8'h00;
      idx_r <= 8'h00;
      istat_r <= '0;
      imask_r <= '0;
      wait_r <= 1'b0;
      stage_r <= 1'b0;
      free_r <= '1;
      hold_r <= '0;
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      ovalid_r <= 1'b0;
      odata_r <= '0;
      obuf_r <= 8'h00;
      oword_r <= 32'h0000_0000;
      ostage_r <= 1'b0;
      sready_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tally_r <= tally_nxt;
      limit_r <= limit_nxt;
      buflen_r <= buflen_nxt;
      wcnt_r <= wcnt_nxt;
      nbufs_r <= nbufs_nxt;
      chen_r <= chen_nxt;
      pend_r <= pend_nxt;
      idx_r <= idx_nxt;
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
      wait_r <= wait_nxt;
      stage_r <= stage_nxt;
      free_r <= free_nxt;
      hold_r <= hold_nxt;
      pready_r <= pready_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      ovalid_r <= ovalid_nxt;
      odata_r <= odata_nxt;
      obuf_r <= obuf_nxt;
      oword_r <= oword_nxt;
      ostage_r <= ostage_nxt;
      sready_r <= sready_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign sample_ready = sready_r;
  assign out_valid = ovalid_r;
  assign out_data = odata_r;
  assign out_buf = obuf_r;
  assign out_word = oword_r;
  assign out_stage = ostage_r;
  assign irq = irq_r;
  assign wait_pending = wait_r;

endmodule

/* tb/fsb_props_properties.sv */
// Purpose: Port checker for the stream buffer controller
// Assumes: One clock domain, reset low
// Notes: Bound into every controller instance
`timescale 1ns/1ns
module fsb_props (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fsb_pkg::ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  // Stream and events
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic out_valid,
  input wire logic [31:0] out_word,
  input wire logic irq,
  input wire logic wait_pending
);
  // ****
  // Rules
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic act;
  logic [31:0] last_r;
  logic [31:0] last_nxt;
  assign wr = psel && penable && pready && pwrite;
  assign act = wr || out_valid;
  always_comb last_nxt = out_valid ? out_word : last_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) last_r <= '0;
    else last_r <= last_nxt;
  ans_time_a: assert property (psel && !penable |-> ##2 pready)
    else $error("pready not two cycles after setup");
  cmd_zero_a: assert property (pready && !pwrite && paddr[17:2] == fsb_pkg::IDX_COMMAND |-> prdata == 0)
    else $error("command word read not zero");
  rel_zero_a: assert property (pready && !pwrite && paddr[17:2] == fsb_pkg::IDX_RELEASE |-> prdata == 0)
    else $error("release word read not zero");
  take_busy_a: assert property (sample_valid && sample_ready |=> !sample_ready)
    else $error("ready stayed high after take");
  word_step_a: assert property (out_valid && out_word != 0 |-> out_word == last_r + 1)
    else $error("word offset skipped");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("irq fell without a write");
  wait_up_a: assert property ($rose(wait_pending) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("wait rose without command");
  wait_down_a: assert property ($fell(wait_pending) |-> act || $past(act) || $past(act, 2))
    else $error("wait fell without cause");
endmodule
bind fsb_stream_ctrl fsb_props fsb_props_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pready, .prdata, .sample_valid, .sample_ready, .out_valid, .out_word, .irq, .wait_pending);

/* tb/fsb_sample_src.sv */
// Purpose: Sample source on the far side of the stream port
// Assumes: Eight 16-bit channels per set
// Notes: Slow mode leaves a gap after every take
`timescale 1ns/1ns
module fsb_sample_src (
  // Clock and control
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic slow,
  // Sample handshake
  input wire logic sample_ready,
  output logic sample_valid,
  output logic [127:0] sample_data
);
  // ****
  // Source
  // ****
  logic [11:0] n_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) begin
      sample_valid <= 1'b0;
      n_r <= 12'h000;
    end else if (!sample_valid || sample_ready) begin
      n_r <= n_r + {11'h000, sample_valid};
      sample_valid <= en && !(slow && sample_valid);
    end
  // Idle lines show the inverse, so stale data never passes for a set
  always_comb
    for (int c = 0; c < 8; c++)
      sample_data[16*c+:16] = sample_valid ? {n_r, c[3:0]} : ~{n_r, c[3:0]};
endmodule

/* tb/fsb_stream_ctrl_tb_top.sv */
// Purpose: Bench for the stream buffer controller
// Assumes: Registers reached over APB at four times the index
// Notes: Buffers stay at 1024 bytes to keep runs short
`timescale 1ns/1ns
module fsb_stream_ctrl_tb_top;
  // ****
  // Bench
  // ****
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, en, slow;
  logic sample_valid, sample_ready, out_valid, out_stage, irq, wait_pending, er;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, out_word, rv;
  logic [127:0] sample_data;
  logic [15:0] out_data;
  logic [7:0] out_buf;
  logic [24:0] q[$];
  logic [11:0] tq[$];
  logic [7:0] modes[6] = '{8'hff, 8'h33, 8'h0f, 8'h11, 8'h03, 8'h01};
  int ord[8] = '{0, 4, 1, 5, 2, 6, 3, 7};
  int bad_count = 0;
  int n_tests = 0;
  fsb_stream_ctrl #(.SAMPLE_W(16)) fsb_stream_ctrl_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .sample_valid, .sample_data,
    .sample_ready, .out_valid, .out_data, .out_buf, .out_word, .out_stage, .irq, .wait_pending);
  fsb_sample_src fsb_sample_src_i (.pclk, .presetn, .en, .slow, .sample_ready, .sample_valid,
    .sample_data);
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) if (out_valid) q.push_back({out_stage, out_buf, out_data});
  // Set numbers as the source hands them over, so expectations never lean on the outputs
  always @(posedge pclk) if (sample_valid && sample_ready) tq.push_back(sample_data[15:4]);
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tmo(input int k);
    if (k >= 3000) begin
      bad_count++;
      final_report();
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] ix, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 3000);
    tmo(k);
    rv = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rchk(input string nm, input logic [15:0] ix, input logic [31:0] exp);
    apb(0, ix, 0);
    check(nm, rv, exp);
  endtask
  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    tmo(k);
  endtask
  initial begin
    int k, j;
    {presetn, psel, penable, pwrite, paddr, pwdata, en, slow} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rchk("limit", fsb_pkg::IDX_LIMIT, 0);
    rchk("tally", fsb_pkg::IDX_TALLY, 0);
    rchk("command", fsb_pkg::IDX_COMMAND, 0);
    rchk("release", fsb_pkg::IDX_RELEASE, 0);
    rchk("buffers", fsb_pkg::IDX_NUM_BUFS, {23'h00_0000, fsb_pkg::RST_NUM_BUFS});
    rchk("length", fsb_pkg::IDX_BUF_LEN, fsb_pkg::RST_BUF_LEN);
    rchk("channels", fsb_pkg::IDX_CHAN_EN, {24'h00_0000, fsb_pkg::RST_CHAN_EN});
    apb(0, 16'h0100, 0);
    check("unmapped", er, 1);
    $display("Test registers done");
    for (int m = 0; m < 6; m++) begin
      apb(1, fsb_pkg::IDX_CHAN_EN, {24'h0, modes[m]});
      q.delete();
      tq.delete();
      apb(1, fsb_pkg::IDX_COMMAND, fsb_pkg::CMD_BEGIN_NOWAIT);
      en <= 1;
      slow <= m[0];
      k = 0;
      while (q.size() < 16 && k < 3000) begin
        @(posedge pclk);
        k++;
      end
      tmo(k);
      apb(1, fsb_pkg::IDX_COMMAND, fsb_pkg::CMD_HALT);
      en <= 0;
      j = 0;
      for (int g = 0; g < 2; g++)
        for (int c = 0; c < 8; c++)
          if (modes[m][ord[c]]) begin
            check("word", q[j][15:0], {tq[0] + g[11:0], ord[c][3:0]});
            j++;
          end
    end
    $display("Test order done");
    apb(1, fsb_pkg::IDX_CHAN_EN, 32'h0000_00ff);
    apb(1, fsb_pkg::IDX_BUF_LEN, 32'h0000_0400);
    apb(1, fsb_pkg::IDX_IRQ_MASK, 32'h0000_0001);
    apb(1, fsb_pkg::IDX_COMMAND, fsb_pkg::CMD_BEGIN_BLOCK);
    repeat (2) @(posedge pclk);
    check("wait", wait_pending, 1);
    en <= 1;
    wait_irq();
    rchk("tally", fsb_pkg::IDX_TALLY, 1);
    check("wait", wait_pending, 0);
    apb(1, fsb_pkg::IDX_IRQ_STAT, 32'h0000_0007);
    apb(1, fsb_pkg::IDX_COMMAND, fsb_pkg::CMD_NEXT_WAIT);
    repeat (2) @(posedge pclk);
    check("wait", wait_pending, 1);
    wait_irq();
    apb(1, fsb_pkg::IDX_TALLY, 32'h0000_0063);
    rchk("tally", fsb_pkg::IDX_TALLY, 2);
    apb(1, fsb_pkg::IDX_IRQ_MASK, 32'h0000_0004);
    // Keep the stall bit: the stall is flagged a few cycles after the second buffer
    apb(1, fsb_pkg::IDX_IRQ_STAT, 32'h0000_0003);
    wait_irq();
    apb(0, fsb_pkg::IDX_STATUS, 0);
    check("stall", rv[fsb_pkg::STS_STALL], 1);
    q.delete();
    apb(1, fsb_pkg::IDX_LEGACY_REL, 0);
    k = 0;
    while (q.size() < 1 && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    tmo(k);
    check("buffer", q[0][23:16], 0);
    check("stage", q[0][24], 0);
    apb(1, fsb_pkg::IDX_RELEASE, 1);
    apb(1, fsb_pkg::IDX_COMMAND, fsb_pkg::CMD_NEXT_WAIT);
    @(posedge pclk);
    check("wait", wait_pending, 1);
    apb(1, fsb_pkg::IDX_COMMAND, fsb_pkg::CMD_HALT);
    apb(0, fsb_pkg::IDX_STATUS, 0);
    check("run", rv[fsb_pkg::STS_RUN], 0);
    check("wait", wait_pending, 0);
    $display("Test flow done");
    apb(1, fsb_pkg::IDX_IRQ_STAT, 32'h0000_0007);
    apb(1, fsb_pkg::IDX_LIMIT, 32'h0000_0002);
    rchk("limit", fsb_pkg::IDX_LIMIT, 2);
    apb(1, fsb_pkg::IDX_IRQ_MASK, 32'h0000_0002);
    apb(1, fsb_pkg::IDX_COMMAND, fsb_pkg::CMD_BEGIN_NOWAIT);
    wait_irq();
    rchk("tally", fsb_pkg::IDX_TALLY, 2);
    apb(0, fsb_pkg::IDX_STATUS, 0);
    check("run", rv[fsb_pkg::STS_RUN], 0);
    rchk("events", fsb_pkg::IDX_IRQ_STAT, 32'h0000_0003);
    $display("Test auto stop done");
    final_report();
  end
endmodule
